// [can_trx_pkg.sv]
// Purpose: shared constants and types of the CAN transceiver mode controller
// Assumes: 10 MHz system clock, APB register access, byte address = 4 * index
// Notes:   the printed register offsets are indexes, not byte addresses
package can_trx_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int SILENCE_TIME_US = 1000;  // bus silence time-out
  localparam int WAKE_DOM_US     = 5;     // least dominant phase of wake pattern
  localparam int WAKE_REC_US     = 5;     // least recessive phase of wake pattern
  localparam int WAKE_TO_US      = 1000;  // longest time for the whole pattern
  // least times round up, longest times round down
  localparam int SILENCE_CYC  = (SILENCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_DOM_CYC = (WAKE_DOM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_REC_CYC = (WAKE_REC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_TO_CYC  = (WAKE_TO_US * 1000) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [9:0] CTRL_IDX     = 10'h020;  // mode and selective wake control
  localparam logic [9:0] TSTAT_IDX    = 10'h022;  // transceiver status
  localparam logic [9:0] WAKECFG_IDX  = 10'h04c;  // bus wake enable
  localparam logic [9:0] EVT_STAT_IDX = 10'h063;  // sticky events, read only
  localparam logic [9:0] EVT_EN_IDX   = 10'h064;  // event enables
  localparam logic [9:0] EVT_CLR_IDX  = 10'h065;  // write one to clear, write only

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CTRL_SEL_LSB   = 0;
  localparam int CTRL_SWE_BIT   = 4;
  localparam int CTRL_SCV_BIT   = 5;
  localparam int CTRL_FD_BIT    = 6;
  localparam int TSTAT_ACT_BIT  = 7;
  localparam int TSTAT_SIL_BIT  = 3;
  localparam int TSTAT_UV_BIT   = 1;
  localparam int WAKECFG_BIT    = 0;
  localparam int EVT_WAKE_BIT   = 0;
  localparam int EVT_TXDLOW_BIT = 1;
  localparam int EVT_W          = 2;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [0:0] WAKECFG_RST = 1'h1;
  localparam logic [1:0] EVT_EN_RST  = 2'h0;

  // ------------------------------------------------------------
  // mode selection encodings and chip operating modes
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_OFFLINE   = 2'h0;
  localparam logic [1:0] SEL_ACTIVE_UV = 2'h1;
  localparam logic [1:0] SEL_ACTIVE    = 2'h2;
  localparam logic [1:0] SEL_LISTEN    = 2'h3;
  localparam logic [1:0] CHIP_NORMAL   = 2'h0;
  localparam logic [1:0] CHIP_STANDBY  = 2'h1;
  localparam logic [1:0] CHIP_SLEEP    = 2'h2;

  typedef enum logic [3:0] {
    ST_ACTIVE  = 4'h1,
    ST_LISTEN  = 4'h2,
    ST_OFFLINE = 4'h4,
    ST_OFFBIAS = 4'h8
  } trx_state_t;

  // drive and bias commands toward the analog bus stage
  typedef struct packed {
    logic tx_dominant;  // drive dominant when drive_en
    logic drive_en;     // transmitter enabled
    logic bias_mid;     // both lines at mid level
    logic bias_gnd;     // both lines at ground
  } bus_drive_t;

endpackage

// [can_wake_detect.sv]
// Purpose: standard dominant-recessive-dominant bus wake pattern detector
// Assumes: i_dominant already synchronised and filtered
// Notes:   extra pulses between phases are tolerated inside the window
`timescale 1ns/1ns
module can_wake_detect #(
  parameter int DOM_CYC = 50,
  parameter int REC_CYC = 50,
  parameter int TO_CYC  = 10000
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_enable,
  input  wire logic i_dominant,
  output logic      o_wake
);

  localparam int CW = $clog2(TO_CYC + 1);

  typedef enum logic [3:0] {
    W_IDLE = 4'h1,
    W_DOM1 = 4'h2,
    W_REC  = 4'h4,
    W_DOM2 = 4'h8
  } wake_state_t;

  wake_state_t   wstate;
  logic [CW-1:0] phase;
  logic [CW-1:0] window;

  initial begin
    if (DOM_CYC < 1 || REC_CYC < 1 || TO_CYC <= DOM_CYC + REC_CYC + DOM_CYC)
      $error("wake detector timing parameters out of range");
  end

  // ------------------------------------------------------------
  // pattern sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    o_wake <= 1'b0;
    if (i_sys_rst || !i_enable || window >= CW'(TO_CYC)) begin
      wstate <= W_IDLE;
      phase  <= '0;
      window <= '0;
    end else begin
      if (wstate != W_IDLE)
        window <= window + 1'b1;
      case (wstate)
        W_IDLE: begin
          if (i_dominant) begin
            wstate <= W_DOM1;
            phase  <= CW'(1);
            window <= CW'(1);
          end
        end
        W_DOM1: begin
          if (i_dominant)
            phase <= phase + 1'b1;
          else if (phase >= CW'(DOM_CYC)) begin
            wstate <= W_REC;
            phase  <= CW'(1);
          end else
            wstate <= W_IDLE;
        end
        W_REC: begin
          if (!i_dominant)
            phase <= phase + 1'b1;
          else if (phase >= CW'(REC_CYC)) begin
            wstate <= W_DOM2;
            phase  <= CW'(1);
          end else
            phase <= CW'(1);  // short glitch, keep waiting for recessive
        end
        W_DOM2: begin
          if (!i_dominant) begin
            wstate <= W_REC;
            phase  <= CW'(1);
          end else if (phase + 1'b1 >= CW'(DOM_CYC)) begin
            o_wake <= 1'b1;
            wstate <= W_IDLE;
            phase  <= '0;
            window <= '0;
          end else
            phase <= phase + 1'b1;
        end
        default: wstate <= W_IDLE;
      endcase
    end
  end

endmodule

// [can_trx_mode_ctrl.sv]
// Purpose: transceiver mode controller with APB registers and wake/silence tracking
// Assumes: one 10 MHz clock; transmit and bus receive inputs are asynchronous pins
// Notes:   APB answers with one access cycle, no wait states
//
// How it works
// R1: in Normal, mode field picks Active, Listen-only or Offline
// R2: in Standby or Sleep, force Offline or Offline Bias by bus activity
// R3: mode field 01 or 10 in Normal selects Active
// R4: with 01, supply undervoltage drops Active to Offline family
// R5: with 10, supply undervoltage ignored while main supply is above reset
// R6: transmit input low on Active request gives Listen-only until it rises
// R7: Active drives bus from transmit input, receive pin shows bus
// R8: Listen-only never drives the bus, receiver and bias stay on
// R9: Active and Listen-only bias both lines at mid level
// R10: Offline biases lines to ground, wake watched only if enabled
// R11: Offline moves to Offline Bias on any bus activity
// R12: Offline Bias returns to Offline after silence time-out
// R13: standard wake pattern watched when selective wake off or invalid
// R14: readable status bit tells whether transceiver is ready
// R15: mode 00 decodes Offline, 11 decodes Listen-only
// R16: status bit 7 reads one only in Active
// R17: wake pattern sets wake flag and pulls receive pin low
// R18: every bus edge restarts the silence timer
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module can_trx_mode_ctrl
  import can_trx_pkg::*;
#(
  parameter int SILENCE_CYCLES = can_trx_pkg::SILENCE_CYC,
  parameter int WAKE_TO_CYCLES = can_trx_pkg::WAKE_TO_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        i_chip_mode,
  input  wire logic              i_transceiver_supply_low,
  input  wire logic              i_main_supply_ok,
  input  wire logic              i_txd,
  input  wire logic              i_bus_rx,
  output logic                   o_rxd,
  output can_trx_pkg::bus_drive_t o_bus_drive,
  output logic                   o_irq
);
  import can_trx_pkg::*;

  localparam int SCW = $clog2(SILENCE_CYCLES + 1);

  initial begin
    if (SILENCE_CYCLES < 1 || WAKE_TO_CYCLES < 1)
      $error("time-out counts must be at least one cycle");
  end

  trx_state_t         state;
  trx_state_t         next_state;
  logic [7:0]         ctrl;
  logic               bus_wake_enable;
  logic [EVT_W-1:0]   evt_stat;
  logic [EVT_W-1:0]   evt_en;
  logic [1:0]         pin_s0;
  logic [1:0]         pin_s1;
  logic [1:0]         pin_s2;
  logic               txd_f;
  logic               rx_f;
  logic               rx_prev;
  logic               rx_edge;
  logic [SCW-1:0]     silence_cnt;
  logic               silent;
  logic               wake;
  logic               wake_watch;
  logic               chip_normal;
  logic [1:0]         transceiver_mode_sel;
  logic               selective_wake_enable;
  logic               selective_config_valid;
  trx_state_t         offline_pick;
  trx_state_t         active_pick;
  logic               setup;
  logic               access;
  logic [9:0]         idx;
  logic               mapped;
  logic               next_txdlow;

  assign transceiver_mode_sel   = ctrl[CTRL_SEL_LSB +: 2];
  assign selective_wake_enable  = ctrl[CTRL_SWE_BIT];
  assign selective_config_valid = ctrl[CTRL_SCV_BIT];
  assign chip_normal            = (i_chip_mode == CHIP_NORMAL);

  // ------------------------------------------------------------
  // pin synchronisers: three flops, a change counts when two agree
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_s0 <= 2'h3;
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
      txd_f  <= 1'b1;
      rx_f   <= 1'b1;
    end else begin
      pin_s0 <= {i_bus_rx, i_txd};
      pin_s1 <= pin_s0;
      pin_s2 <= pin_s1;
      if (pin_s1[0] == pin_s2[0])
        txd_f <= pin_s2[0];
      if (pin_s1[1] == pin_s2[1])
        rx_f <= pin_s2[1];
    end
  end

  // ------------------------------------------------------------
  // bus activity and silence timer
  // ------------------------------------------------------------
  assign rx_edge = (rx_f != rx_prev);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_prev     <= 1'b1;
      silence_cnt <= '0;
      silent      <= 1'b1;
    end else begin
      rx_prev <= rx_f;
      if (rx_edge) begin
        silence_cnt <= '0;  // R18
        silent      <= 1'b0;
      end else if (silence_cnt >= SCW'(SILENCE_CYCLES))
        silent <= 1'b1;
      else
        silence_cnt <= silence_cnt + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // mode selection
  // ------------------------------------------------------------
  always_comb begin
    // offline family: follow bus activity
    offline_pick = state;
    if (state == ST_OFFLINE && rx_edge)
      offline_pick = ST_OFFBIAS;  // R11
    else if (state == ST_OFFBIAS && silent)
      offline_pick = ST_OFFLINE;  // R12
    else if (state == ST_ACTIVE || state == ST_LISTEN)
      offline_pick = silent ? ST_OFFLINE : ST_OFFBIAS;
    // stuck-low transmit input keeps the transmitter off
    if (state == ST_ACTIVE || txd_f)
      active_pick = ST_ACTIVE;
    else
      active_pick = ST_LISTEN;  // R6
    next_state = offline_pick;
    if (chip_normal) begin  // R1
      case (transceiver_mode_sel)
        SEL_OFFLINE:   next_state = offline_pick;  // R15
        SEL_LISTEN:    next_state = ST_LISTEN;  // R15
        SEL_ACTIVE_UV: next_state = i_transceiver_supply_low ? offline_pick : active_pick;  // R3 R4
        SEL_ACTIVE:    next_state = i_main_supply_ok ? active_pick : offline_pick;  // R3 R5
        default:       next_state = offline_pick;
      endcase
    end
  end

  assign next_txdlow = (next_state == ST_LISTEN) && !txd_f && chip_normal
                       && transceiver_mode_sel != SEL_LISTEN;

  // state and bus stage commands, registered together
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state       <= ST_OFFLINE;
      o_bus_drive <= '{tx_dominant: 1'b0, drive_en: 1'b0, bias_mid: 1'b0, bias_gnd: 1'b1};
    end else begin
      state                   <= next_state;  // R2
      o_bus_drive.drive_en    <= (next_state == ST_ACTIVE);  // R8
      o_bus_drive.tx_dominant <= (next_state == ST_ACTIVE) && !txd_f;  // R7
      o_bus_drive.bias_mid    <= (next_state != ST_OFFLINE);  // R9
      o_bus_drive.bias_gnd    <= (next_state == ST_OFFLINE);  // R10
    end
  end

  // ------------------------------------------------------------
  // standard wake detection
  // ------------------------------------------------------------
  // offline bias differs from offline only in biasing, so the pattern is watched in both
  assign wake_watch = (state == ST_OFFLINE || state == ST_OFFBIAS) && bus_wake_enable
                      && !(selective_wake_enable && selective_config_valid);  // R10 R13

  can_wake_detect #(
    .DOM_CYC (WAKE_DOM_CYC),
    .REC_CYC (WAKE_REC_CYC),
    .TO_CYC  (WAKE_TO_CYCLES)
  ) u_wake (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_enable   (wake_watch),
    .i_dominant (!rx_f),
    .o_wake     (wake)
  );

  // receive pin: bus level when receiving, low after a wake
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)
      o_rxd <= 1'b1;
    else if (next_state == ST_ACTIVE || next_state == ST_LISTEN)
      o_rxd <= rx_f;  // R7
    else
      o_rxd <= !(wake || evt_stat[EVT_WAKE_BIT]);  // R17
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign idx    = paddr[11:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx == CTRL_IDX || idx == TSTAT_IDX
                  || idx == WAKECFG_IDX || idx == EVT_STAT_IDX
                  || idx == EVT_EN_IDX || idx == EVT_CLR_IDX);

  // answer is prepared in the setup cycle and shown in the access cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && (!mapped || (pwrite && (idx == TSTAT_IDX || idx == EVT_STAT_IDX)));
      prdata  <= 32'h0;
      if (setup && !pwrite) begin
        case (idx)
          CTRL_IDX:     prdata[7:0] <= {1'b0, ctrl[6:4], 2'h0, ctrl[1:0]};
          TSTAT_IDX: begin
            prdata[TSTAT_ACT_BIT] <= (state == ST_ACTIVE);  // R14 R16
            prdata[TSTAT_SIL_BIT] <= silent;
            prdata[TSTAT_UV_BIT]  <= i_transceiver_supply_low
                                     && transceiver_mode_sel == SEL_ACTIVE_UV;
          end
          WAKECFG_IDX:  prdata[WAKECFG_BIT] <= bus_wake_enable;
          EVT_STAT_IDX: prdata[EVT_W-1:0] <= evt_stat;
          EVT_EN_IDX:   prdata[EVT_W-1:0] <= evt_en;
          default:      prdata <= 32'h0;
        endcase
      end
    end
  end

  // writable control registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl            <= CTRL_RST;
      bus_wake_enable <= WAKECFG_RST;
      evt_en          <= EVT_EN_RST;
    end else if (access && pwrite && !pslverr) begin
      if (idx == CTRL_IDX)
        ctrl <= pwdata[7:0] & 8'h73;
      if (idx == WAKECFG_IDX)
        bus_wake_enable <= pwdata[WAKECFG_BIT];
      if (idx == EVT_EN_IDX)
        evt_en <= pwdata[EVT_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // sticky events and interrupt; a set wins over a clear
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      evt_stat <= '0;
      o_irq    <= 1'b0;
    end else begin
      if (access && pwrite && !pslverr && idx == EVT_CLR_IDX)
        evt_stat <= (evt_stat & ~pwdata[EVT_W-1:0])
                    | {next_txdlow, wake};  // R17
      else
        evt_stat <= evt_stat | {next_txdlow, wake};  // R17
      o_irq <= |(evt_stat & evt_en);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_NORMAL_LISTEN: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R1
    chip_normal && transceiver_mode_sel == SEL_LISTEN |=> state == ST_LISTEN)
    else $error("listen-only selection not followed");
  AST_FORCED_OFF: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R2
    !chip_normal |=> state == ST_OFFLINE || state == ST_OFFBIAS)
    else $error("standby or sleep left transceiver on");
  AST_UV_DROP: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R4
    chip_normal && transceiver_mode_sel == SEL_ACTIVE_UV && i_transceiver_supply_low
    |=> !o_bus_drive.drive_en && state != ST_ACTIVE)
    else $error("undervoltage did not stop transmitter");
  AST_UV_IGNORED: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R5
    chip_normal && transceiver_mode_sel == SEL_ACTIVE && i_main_supply_ok
    && state == ST_ACTIVE |=> state == ST_ACTIVE)
    else $error("active left while undervoltage ignored");
  AST_TXD_STUCK: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R6
    state != ST_ACTIVE && !txd_f |=> state != ST_ACTIVE)
    else $error("active entered with transmit input low");
  AST_TX_FOLLOWS: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R7
    state == ST_ACTIVE |-> o_bus_drive.drive_en && o_bus_drive.tx_dominant == !$past(txd_f))
    else $error("bus drive does not follow transmit input");
  AST_LISTEN_QUIET: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R8
    state == ST_LISTEN |-> !o_bus_drive.drive_en && o_bus_drive.bias_mid)
    else $error("listen-only drives the bus");
  AST_OFF_GND: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R10
    state == ST_OFFLINE |-> o_bus_drive.bias_gnd && !o_bus_drive.bias_mid)
    else $error("offline not biased to ground");
  AST_ACTIVITY_BIAS: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R11
    (!chip_normal || transceiver_mode_sel == SEL_OFFLINE)
    && state == ST_OFFLINE && rx_edge |=> state == ST_OFFBIAS)
    else $error("bus activity did not raise bias");
  AST_SILENCE_BACK: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R12
    (!chip_normal || transceiver_mode_sel == SEL_OFFLINE)
    && state == ST_OFFBIAS && silent |=> state == ST_OFFLINE)
    else $error("silence did not return to offline");
  AST_WAKE_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R17
    wake |=> evt_stat[EVT_WAKE_BIT] && (!o_rxd || state == ST_ACTIVE || state == ST_LISTEN))
    else $error("wake not flagged");
  AST_EDGE_RESTART: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R18
    rx_edge |=> silence_cnt == '0 && !silent)
    else $error("bus edge did not restart silence timer");

endmodule

// [can_bus_partner.sv]
// Purpose: behavioural protocol controller and remote bus node
// Assumes: the bus is a wired-and of all transmitters, high = recessive
// Notes:   transmit level and remote node are commanded by the bench
`timescale 1ns/1ns
module can_bus_partner
  import can_trx_pkg::*;
(
  input  wire logic                    i_ctl_txd,
  input  wire logic                    i_remote_dom,
  input  wire can_trx_pkg::bus_drive_t i_drive,
  output logic                         o_txd,
  output logic                         o_bus_rx
);
  // controller transmit pin follows the bench command
  assign o_txd = i_ctl_txd;
  // dominant from either node wins on the shared bus
  assign o_bus_rx = ~(i_remote_dom | (i_drive.drive_en & i_drive.tx_dominant));
endmodule

// [can_transceiver_mode_control_tb_top.sv]
// Purpose: self-checking bench of the transceiver mode controller
// Assumes: pins settle through the input synchronisers within 8 cycles
// Notes:   silence and wake time-outs are shortened by parameter
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module can_transceiver_mode_control_tb_top;
  import can_trx_pkg::*;
  localparam int SIL = 200;
  logic        i_clk, i_sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  chip_mode;
  logic        sup_low, main_ok, ctl_txd, remote_dom, txd, bus_rx, o_rxd, o_irq;
  bus_drive_t  o_bus_drive;
  int          err_count, check_count;

  can_trx_mode_ctrl #(.SILENCE_CYCLES(SIL), .WAKE_TO_CYCLES(400)) can_trx_mode_ctrl_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_chip_mode(chip_mode),
    .i_transceiver_supply_low(sup_low), .i_main_supply_ok(main_ok),
    .i_txd(txd), .i_bus_rx(bus_rx), .o_rxd(o_rxd), .o_bus_drive(o_bus_drive),
    .o_irq(o_irq));
  can_bus_partner can_bus_partner_inst (
    .i_ctl_txd(ctl_txd), .i_remote_dom(remote_dom), .i_drive(o_bus_drive),
    .o_txd(txd), .o_bus_rx(bus_rx));

  // ------------------------------------------------------------
  // bus cycles and helpers
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 10);
    if (n >= 10) begin
      err_count++;
      $display("FAIL t=%0t apb transfer timed out", $time);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // quiet bus, then dominant, recessive, dominant of 60 cycles each
  task automatic pattern();
    cyc(SIL + 20);
    remote_dom <= 1'b1;
    cyc(60);
    remote_dom <= 1'b0;
    cyc(60);
    remote_dom <= 1'b1;
    cyc(60);
    remote_dom <= 1'b0;
    cyc(8);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    `CHK(o_bus_drive, 4'h1)
    rchk(12'h080, 32'h0);
    rchk(12'h130, 32'h1);
    rchk(12'h088, 32'h8);
    wr(12'h088, 32'hff);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h3fc, 32'h0);
    `CHK(err, 1'b1)
    $display("reset test done");
  endtask
  task automatic t_active();
    ctl_txd <= 1'b0;
    cyc(8);
    wr(12'h080, 32'h2);
    cyc(8);
    `CHK(o_bus_drive, 4'h2)
    rchk(12'h18c, 32'h2);
    apb(1'b0, 12'h088, 32'h0);
    `CHK(rd[7], 1'b0)
    ctl_txd <= 1'b1;
    cyc(8);
    `CHK(o_bus_drive, 4'h6)
    apb(1'b0, 12'h088, 32'h0);
    `CHK(rd[7], 1'b1)
    // transmit pin to bus and back passes both synchronisers
    ctl_txd <= 1'b0;
    cyc(12);
    `CHK(o_bus_drive, 4'he)
    `CHK(o_rxd, 1'b0)
    ctl_txd <= 1'b1;
    cyc(12);
    `CHK(o_rxd, 1'b1)
    $display("active test done");
  endtask
  task automatic t_supply();
    sup_low <= 1'b1;
    cyc(8);
    `CHK(o_bus_drive, 4'h6)
    main_ok <= 1'b0;
    cyc(8);
    `CHK(o_bus_drive.drive_en, 1'b0)
    main_ok <= 1'b1;
    cyc(8);
    `CHK(o_bus_drive, 4'h6)
    wr(12'h080, 32'h1);
    cyc(8);
    `CHK(o_bus_drive.drive_en, 1'b0)
    apb(1'b0, 12'h088, 32'h0);
    `CHK(rd[1], 1'b1)
    sup_low <= 1'b0;
    cyc(8);
    `CHK(o_bus_drive, 4'h6)
    $display("supply test done");
  endtask
  task automatic t_decode();
    wr(12'h080, 32'h3);
    cyc(4);
    `CHK(o_bus_drive, 4'h2)
    wr(12'h080, 32'h0);
    cyc(SIL + 20);
    `CHK(o_bus_drive, 4'h1)
    wr(12'h080, 32'h2);
    for (int m = 1; m < 4; m++) begin
      chip_mode <= 2'(m);
      cyc(SIL + 20);
      `CHK(o_bus_drive, 4'h1)
    end
    chip_mode <= CHIP_NORMAL;
    cyc(8);
    `CHK(o_bus_drive, 4'h6)
    $display("decode test done");
  endtask
  task automatic t_silence();
    wr(12'h080, 32'h0);
    cyc(SIL + 20);
    remote_dom <= 1'b1;
    cyc(8);
    `CHK(o_bus_drive, 4'h2)
    repeat (3) begin
      remote_dom <= ~remote_dom;
      cyc(150);
    end
    `CHK(o_bus_drive, 4'h2)
    cyc(70);
    `CHK(o_bus_drive, 4'h1)
    $display("silence test done");
  endtask
  task automatic t_wake();
    wr(12'h194, 32'h3);
    wr(12'h190, 32'h1);
    pattern();
    rchk(12'h18c, 32'h1);
    `CHK(o_rxd, 1'b0)
    `CHK(o_irq, 1'b1)
    wr(12'h194, 32'h1);
    cyc(3);
    `CHK(o_irq, 1'b0)
    wr(12'h080, 32'h10);
    pattern();
    rchk(12'h18c, 32'h1);
    wr(12'h194, 32'h1);
    wr(12'h080, 32'h30);
    pattern();
    rchk(12'h18c, 32'h0);
    wr(12'h080, 32'h0);
    wr(12'h130, 32'h0);
    pattern();
    rchk(12'h18c, 32'h0);
    $display("wake test done");
  endtask

  // ------------------------------------------------------------
  // clock, reset and main sequence
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {chip_mode, sup_low, ctl_txd, remote_dom} = '0;
    main_ok = 1'b1;
    i_sys_rst = 1'b1;
    err_count = 0;
    check_count = 0;
    cyc(2);
    i_sys_rst <= 1'b0;
    cyc(4);
    t_reset();
    t_active();
    t_supply();
    t_decode();
    t_silence();
    t_wake();
    report_and_stop();
  end
endmodule
